/* File: hw/fhc_pkg.sv */
// constants and carrier types for the floppy host command port
// assumes one 10 MHz clock and a synchronous active-high reset
// How it works
// R1: select low with read gives status byte; select high with read gives data byte
// R2: host never strobes read and write together nor writes with select low
// R3: main status byte is readable at any time and is read-only
// R4: status bits 0 to 3 follow per-drive seek activity
// R5: bit 4 is set while a read or write command is processed
// R6: bit 5 is set only during a non-dma execution phase
// R7: bit 6 is one when bytes flow toward the host
// R8: bit 7 is set only when the data port can move a byte
// R9: ready flag drops for a fixed delay after every data port access
// R10: host checks status before each command byte and writes only when allowed
// R11: host checks status before each result byte and reads only when allowed
// R12: host need not poll status during execution
// R13: non-dma read raises interrupt per byte; data read clears it
// R14: non-dma write clears the interrupt on the host write strobe
// R15: host may poll bit 7 instead of servicing interrupts
// R16: sectors keep moving until terminal count; host drives it in non-dma mode
// R17: dma mode gives no execution interrupts and requests each byte
// R18: dma request drops when the grant goes low; grant comes with a strobe
// R19: terminal count ends execution with an interrupt, cleared automatically
// R20: all result bytes must be read before a new command is taken
// R21: status bytes appear only in the result phase; count set by command
// R22: host sends command bytes in order and skips no result byte
// R23: execution starts after last command byte; idle after last result byte
// R24: terminal count aborts a command in progress
// R25: after reset idle with ready set and direction cleared
package fhc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned READY_GAP_NS = 12000;
  // ready gap rounded up to whole cycles
  localparam int unsigned READY_GAP_CYC = (READY_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] MSR_RESET = 8'h80;
  localparam int unsigned MSR_SEEK_LSB = 0;
  localparam int unsigned MSR_BUSY_BIT = 4;
  localparam int unsigned MSR_PIO_BIT = 5;
  localparam int unsigned MSR_DIR_BIT = 6;
  localparam int unsigned MSR_READY_BIT = 7;
  localparam logic [4:0] OPC_READ_DATA = 5'h06;
  localparam logic [4:0] OPC_WRITE_DATA = 5'h05;
  localparam logic [3:0] RW_CMD_LEN = 4'h9;
  localparam logic [3:0] RW_RES_LEN = 4'h7;
  localparam logic [3:0] OTHER_CMD_LEN = 4'h1;
  localparam logic [3:0] OTHER_RES_LEN = 4'h1;
  localparam logic [7:0] INVALID_RES = 8'h80;
  typedef enum logic [1:0] {
    FHC_CMD = 2'b00,
    FHC_EXEC = 2'b01,
    FHC_RES = 2'b10
  } fhc_phase_e;
  // one host bus access as seen by the port
  typedef struct packed {
    logic sel;
    logic rd_n;
    logic wr_n;
    logic [7:0] data;
  } fhc_bus_s;
endpackage : fhc_pkg

/* File: hw/fhc_port.sv */
// processor-side command port of a floppy controller
// assumes host strobes synchronous to CLK_IN and held one or more cycles
// the disk side hands bytes over on DISK_* with a one-cycle strobe
module fhc_port
  import fhc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SEL_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic DMA_GRANT_N_IN,
  input wire logic TERMINAL_COUNT_IN,
  input wire logic NON_DMA_IN,
  input wire logic [3:0] SEEK_ACTIVE_IN,
  input wire logic DISK_BYTE_VALID_IN,
  input wire logic [7:0] DISK_BYTE_IN,
  input wire logic [7:0] STATUS_BYTE_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic INT_OUT,
  output logic DMA_REQUEST_OUT,
  output logic DISK_BYTE_TAKEN_OUT,
  output logic [7:0] DISK_WRITE_BYTE_OUT,
  output logic EXEC_ACTIVE_OUT,
  output logic EXEC_WRITE_OUT
);
  fhc_bus_s bus;
  fhc_bus_s bus_q;
  fhc_phase_e phase_q;
  logic [3:0] count_q;
  logic [3:0] len_q;
  logic is_write_q;
  logic rw_cmd_q;
  logic ready_q;
  logic [7:0] gap_q;
  logic pend_q;
  logic [7:0] byte_q;
  logic [7:0] msr;
  logic rd_edge;
  logic wr_edge;
  logic data_rd;
  logic data_wr;
  logic tc_exec;

  assign bus = '{sel: SEL_IN, rd_n: RD_N_IN, wr_n: WR_N_IN, data: DATA_IN};

  // strobe edges; illegal strobe pairs are not decoded
  assign rd_edge = !bus.rd_n && bus_q.rd_n && bus.wr_n; // R2
  assign wr_edge = !bus.wr_n && bus_q.wr_n && bus.rd_n && bus.sel; // R2
  assign data_rd = rd_edge && bus.sel; // R1
  assign data_wr = wr_edge;
  assign tc_exec = TERMINAL_COUNT_IN && phase_q == FHC_EXEC; // R16 R24

  // main status byte assembled from live state
  always_comb begin
    msr = 8'h00;
    msr[MSR_SEEK_LSB +: 4] = SEEK_ACTIVE_IN; // R4
    msr[MSR_BUSY_BIT] = rw_cmd_q && phase_q != FHC_CMD; // R5
    msr[MSR_PIO_BIT] = phase_q == FHC_EXEC && NON_DMA_IN; // R6
    msr[MSR_DIR_BIT] = phase_q == FHC_RES || (phase_q == FHC_EXEC && !is_write_q); // R7
    msr[MSR_READY_BIT] = ready_q; // R8
  end

  // previous strobe levels for edge detection
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      bus_q <= '{sel: 1'b0, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00};
    end else begin
      bus_q <= bus;
    end
  end

  // command, execution and result phase sequencing
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      phase_q <= FHC_CMD; // R25
      count_q <= 4'h0;
      len_q <= OTHER_CMD_LEN;
      is_write_q <= 1'b0;
      rw_cmd_q <= 1'b0;
    end else begin
      case (phase_q)
        FHC_CMD: begin
          if (data_wr && ready_q && !msr[MSR_DIR_BIT]) begin // R10
            if (count_q == 4'h0) begin
              // opcode byte picks lengths and direction
              rw_cmd_q <= bus.data[4:0] == OPC_READ_DATA || bus.data[4:0] == OPC_WRITE_DATA;
              is_write_q <= bus.data[4:0] == OPC_WRITE_DATA;
              if (bus.data[4:0] == OPC_READ_DATA || bus.data[4:0] == OPC_WRITE_DATA) begin
                len_q <= RW_CMD_LEN;
                count_q <= 4'h1;
              end else begin
                len_q <= OTHER_RES_LEN; // R21
                count_q <= 4'h0;
                phase_q <= FHC_RES;
              end
            end else if (count_q == len_q - 4'h1) begin
              count_q <= 4'h0;
              phase_q <= FHC_EXEC; // R23
            end else begin
              count_q <= count_q + 4'h1; // R22
            end
          end
        end
        FHC_EXEC: begin
          if (tc_exec) begin
            len_q <= RW_RES_LEN; // R21
            count_q <= 4'h0;
            phase_q <= FHC_RES; // R16 R24
          end
        end
        FHC_RES: begin
          if (data_rd && ready_q) begin // R11
            if (count_q == len_q - 4'h1) begin
              count_q <= 4'h0;
              rw_cmd_q <= 1'b0;
              is_write_q <= 1'b0;
              phase_q <= FHC_CMD; // R20 R23
            end else begin
              count_q <= count_q + 4'h1;
            end
          end
        end
        default: begin
          phase_q <= FHC_CMD;
        end
      endcase
    end
  end

  // ready flag with post-access gap and execution byte pacing
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ready_q <= 1'b1; // R25
      gap_q <= 8'h00;
    end else if (data_rd || data_wr) begin
      ready_q <= 1'b0; // R9
      gap_q <= 8'(READY_GAP_CYC);
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01; // R9
      ready_q <= 1'b0;
    end else if (phase_q == FHC_EXEC) begin
      ready_q <= NON_DMA_IN && (is_write_q ? !pend_q : pend_q); // R8 R15
    end else begin
      ready_q <= 1'b1;
    end
  end

  // execution byte holder between disk side and host
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pend_q <= 1'b0;
      byte_q <= 8'h00;
    end else if (phase_q != FHC_EXEC || tc_exec) begin
      pend_q <= 1'b0;
    end else if (!is_write_q) begin
      if (DISK_BYTE_VALID_IN) begin
        pend_q <= 1'b1; // set wins over host read
        byte_q <= DISK_BYTE_IN;
      end else if (data_rd) begin
        pend_q <= 1'b0;
      end
    end else begin
      if (data_wr) begin
        pend_q <= 1'b1;
        byte_q <= bus.data;
      end else if (DISK_BYTE_VALID_IN) begin
        pend_q <= 1'b0;
      end
    end
  end

  // interrupt: per byte in non-dma execution, one pulse at terminal count
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      INT_OUT <= 1'b0;
    end else if (tc_exec) begin
      INT_OUT <= 1'b1; // R19
    end else if (phase_q == FHC_EXEC && NON_DMA_IN) begin // R17
      if (!is_write_q) begin
        INT_OUT <= DISK_BYTE_VALID_IN || (INT_OUT && !data_rd); // R13
      end else begin
        INT_OUT <= DISK_BYTE_VALID_IN || (INT_OUT && !data_wr); // R14
      end
    end else begin
      INT_OUT <= 1'b0; // R19
    end
  end

  // dma request per byte, dropped on grant
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      DMA_REQUEST_OUT <= 1'b0;
    end else if (phase_q != FHC_EXEC || NON_DMA_IN || tc_exec) begin
      DMA_REQUEST_OUT <= 1'b0; // R17
    end else if (!DMA_GRANT_N_IN) begin
      DMA_REQUEST_OUT <= 1'b0; // R18
    end else if (DISK_BYTE_VALID_IN) begin
      DMA_REQUEST_OUT <= 1'b1; // R17
    end
  end

  // read data path: status or data port
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      DATA_OUT <= 8'h00;
      DATA_OE_OUT <= 1'b0;
    end else begin
      DATA_OE_OUT <= !bus.rd_n && bus.wr_n; // R2
      if (!bus.sel) begin
        DATA_OUT <= msr; // R1 R3
      end else if (phase_q == FHC_RES) begin
        DATA_OUT <= rw_cmd_q ? STATUS_BYTE_IN : INVALID_RES; // R21
      end else begin
        DATA_OUT <= byte_q; // R1
      end
    end
  end

  // disk-side handoff signals
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      DISK_BYTE_TAKEN_OUT <= 1'b0;
      DISK_WRITE_BYTE_OUT <= 8'h00;
      EXEC_ACTIVE_OUT <= 1'b0;
      EXEC_WRITE_OUT <= 1'b0;
    end else begin
      DISK_BYTE_TAKEN_OUT <= phase_q == FHC_EXEC && (data_rd || data_wr);
      DISK_WRITE_BYTE_OUT <= byte_q;
      EXEC_ACTIVE_OUT <= phase_q == FHC_EXEC && !tc_exec;
      EXEC_WRITE_OUT <= is_write_q;
    end
  end
endmodule : fhc_port

/* File: test/fhc_dma_model.sv */
// dma controller stand-in answering read requests of the port
// assumes requests are level and data is registered on the port side
module fhc_dma_model #(
  parameter int WAIT_CYC = 3
) (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [7:0] data_in,
  output logic grant_n_out,
  output logic rd_n_out,
  output logic [7:0] got_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // grant with a read strobe, hold two edges, take the byte
  initial begin
    {grant_n_out, rd_n_out, got_out} = 10'h3ff;
    forever begin
      @(posedge clk_in);
      if (req_in === 1'b1) begin
        repeat (WAIT_CYC) @(posedge clk_in);
        #1 {grant_n_out, rd_n_out} = 2'b00;
        repeat (2) @(posedge clk_in);
        got_out = data_in;
        #1 {grant_n_out, rd_n_out} = 2'b11;
      end
    end
  end
endmodule : fhc_dma_model

/* File: test/fhc_port_checker.sv */
// assertion checker for the floppy host command port
// assumes it is bound onto fhc_port and sees only its pins
module fhc_port_checker (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SEL_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic DMA_GRANT_N_IN,
  input wire logic TERMINAL_COUNT_IN,
  input wire logic NON_DMA_IN,
  input wire logic [3:0] SEEK_ACTIVE_IN,
  input wire logic DISK_BYTE_VALID_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_OUT,
  input wire logic INT_OUT,
  input wire logic DMA_REQUEST_OUT,
  input wire logic EXEC_ACTIVE_OUT,
  input wire logic EXEC_WRITE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // bus drive and status fields on reads
  a_oe_on_read: assert property (
    !RD_N_IN && WR_N_IN |=> DATA_OE_OUT) else $error("bus not driven on read");
  a_seek_bits: assert property (
    !SEL_IN && !RD_N_IN |=> DATA_OUT[3:0] == $past(SEEK_ACTIVE_IN)) else $error("seek bits");
  a_busy_exec: assert property (
    !SEL_IN && !RD_N_IN && EXEC_ACTIVE_OUT |=> DATA_OUT[4]) else $error("busy bit low");
  a_pio_bit: assert property (
    !SEL_IN && !RD_N_IN && !TERMINAL_COUNT_IN
    |=> DATA_OUT[5] == (EXEC_ACTIVE_OUT && $past(NON_DMA_IN)))
    else $error("pio bit wrong");
  // byte and terminal count events in the execution phase
  a_pio_int: assert property (
    DISK_BYTE_VALID_IN && NON_DMA_IN && EXEC_ACTIVE_OUT && !EXEC_WRITE_OUT |=> INT_OUT)
    else $error("no byte interrupt");
  a_dma_req: assert property (
    DISK_BYTE_VALID_IN && !NON_DMA_IN && EXEC_ACTIVE_OUT && DMA_GRANT_N_IN
    && !TERMINAL_COUNT_IN |=> DMA_REQUEST_OUT && !INT_OUT)
    else $error("dma request missing");
  a_grant_drop: assert property (
    $fell(DMA_GRANT_N_IN) && !DISK_BYTE_VALID_IN |=> !DMA_REQUEST_OUT)
    else $error("request held after grant");
  a_tc_int: assert property (
    EXEC_ACTIVE_OUT && TERMINAL_COUNT_IN |=> INT_OUT && !EXEC_ACTIVE_OUT ##1 !INT_OUT)
    else $error("end interrupt wrong");
endmodule : fhc_port_checker

/* File: test/fhc_port_tb.sv */
// self-checking bench for the floppy host command port
// assumes fhc_pkg, fhc_port, the checker and the dma model are compiled first
module fhc_port_tb import fhc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, sel, rd_n, wr_n, tc, pio_execution_flag, dv, g_n, m_rd_n, oe, irq, req, ex, taken, exw;
  logic [7:0] din, db, sb, dout, got, v, wb;
  logic [3:0] seek;
  int err_total = 0;
  int total_checks = 0;
  int npoll;
  // clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  fhc_port i_dut (.CLK_IN(clk), .RST_IN(rst), .SEL_IN(sel), .RD_N_IN(rd_n & m_rd_n),
    .WR_N_IN(wr_n), .DATA_IN(din), .DMA_GRANT_N_IN(g_n), .TERMINAL_COUNT_IN(tc),
    .NON_DMA_IN(pio_execution_flag), .SEEK_ACTIVE_IN(seek), .DISK_BYTE_VALID_IN(dv), .DISK_BYTE_IN(db),
    .STATUS_BYTE_IN(sb), .DATA_OUT(dout), .DATA_OE_OUT(oe), .INT_OUT(irq),
    .DMA_REQUEST_OUT(req), .DISK_BYTE_TAKEN_OUT(taken), .DISK_WRITE_BYTE_OUT(wb),
    .EXEC_ACTIVE_OUT(ex), .EXEC_WRITE_OUT(exw));
  fhc_dma_model i_dma (.clk_in(clk), .req_in(req), .data_in(dout), .grant_n_out(g_n),
    .rd_n_out(m_rd_n), .got_out(got));
  // host bus cycles and comparison
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    total_checks++;
    if (a !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk
  task automatic rd(input logic s, output logic [7:0] d);
    @(posedge clk) #1 sel = s;
    rd_n = 1'b0;
    @(posedge clk) #1 d = dout;
    rd_n = 1'b1;
  endtask : rd
  task automatic wr(input logic s, input logic [7:0] d);
    @(posedge clk) #1 {sel, din, wr_n} = {s, d, 1'b0};
    @(posedge clk) #1 wr_n = 1'b1;
  endtask : wr
  task automatic wait_rdy();
    v = 8'h00;
    for (npoll = 0; npoll < 400 && v[7] !== 1'b1; npoll++) rd(1'b0, v);
    // a ready flag that never comes is a mismatch and ends the run
    if (v[7] !== 1'b1) begin
      chk(v, 8'h80);
      give_verdict();
    end
  endtask : wait_rdy
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1'b1;
    @(posedge clk) #1 s = 1'b0;
  endtask : pulse
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // reset, short command, then write data in pio mode and read data in pio and dma mode
  initial begin
    {rst, sel, rd_n, wr_n} = 4'hf;
    {tc, pio_execution_flag, dv, seek, din, db, sb} = 31'h0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd(1'b0, v);
    chk(v, MSR_RESET);
    wr(1'b0, 8'h06);
    rd(1'b0, v);
    chk(v, MSR_RESET);
    wr(1'b1, 8'h08);
    rd(1'b0, v);
    chk({7'h00, v[7]}, 8'h00);
    wait_rdy();
    chk({7'h00, npoll > 50 && npoll < 66}, 8'h01);
    chk(v, 8'hc0);
    rd(1'b1, v);
    chk(v, INVALID_RES);
    wait_rdy();
    chk(v, MSR_RESET);
    // m 2: pio write, m 1: pio read, m 0: dma read
    for (int m = 2; m >= 0; m--) begin
      pio_execution_flag = m != 0;
      for (int k = 0; k < RW_CMD_LEN; k++) begin
        wr(1'b1, k != 0 ? 8'h01 : {3'b000, m == 2 ? OPC_WRITE_DATA : OPC_READ_DATA});
        if (k < RW_CMD_LEN - 1) wait_rdy();
      end
      @(posedge clk) #1;
      chk({6'h00, ex, exw}, {6'h00, 1'b1, m == 2});
      rd(1'b0, v);
      chk({6'h00, v[5:4]}, {6'h00, pio_execution_flag, 1'b1});
      {sel, sb, db, seek} = {1'b1, 8'h5a, 8'h3c, 4'h5};
      if (m == 2) begin
        wait_rdy();
        chk(v, 8'hb5);
        wr(1'b1, 8'ha7);
        chk({7'h00, taken}, 8'h01);
        pulse(dv);
        chk(wb, 8'ha7);
        chk({7'h00, irq}, 8'h01);
        wait_rdy();
        wr(1'b1, 8'h4b);
        chk({7'h00, irq}, 8'h00);
      end else begin
        pulse(dv);
        chk({7'h00, irq}, {7'h00, pio_execution_flag});
        if (m == 1) begin
          wait_rdy();
          chk(v, 8'hf5);
          rd(1'b1, v);
        end else begin
          repeat (10) @(posedge clk) #1;
          v = got;
        end
        chk(v, 8'h3c);
        chk({6'h00, irq, req}, 8'h00);
      end
      pulse(tc);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk) #1;
      chk({7'h00, irq}, 8'h00);
      for (int r = 0; r < RW_RES_LEN; r++) begin
        wait_rdy();
        rd(1'b1, v);
        chk(v, sb);
      end
      wait_rdy();
      chk(v, 8'h85);
      seek = 4'h0;
    end
    give_verdict();
  end
  // cut a hang short
  initial begin
    #3000000;
    err_total++;
    give_verdict();
  end
endmodule : fhc_port_tb
bind fhc_port fhc_port_checker i_chk (.*);
